// ==== rtl/sbm_pixel_path.sv ====
/*
  Pixel output path: binning, mirror, three test patterns, frame timing and link output.
  Assumes a sensor readout port returning data one cycle after a read, on the core clock,
  and a trigger pin asynchronous to the core clock.
*/
// Behaviour
// - Horizontal binning outputs one summed pixel per adjacent pixel pair in a line.
// - Vertical binning sums same-column pixels of two neighbouring lines.
// - Both enables give full binning, summing four adjacent pixels.
// - Frame is 502x1004 hbin, 1004x502 vbin, 502x502 full.
// - Pixel clock 40 MHz, 20 MHz with horizontal or full binning.
// - Vertical or full binning uses the longer line period plus fixed frame overhead.
// - Horizontal binning alone keeps frame period unchanged.
// - Colour variant has no binning.
// - Mirror reverses pixel order within each line.
// - One value per pixel, no colour interpolation.
// - Test patterns ignore gain, offset and exposure.
// - Binning still applies to test patterns.
// - Trigger mode sends one frame per trigger cycle.
// - Free-run sends one frame per internal control cycle.
// - Three test patterns made purely in logic, sensor unused.
// - Pattern one left half falls from 255-(n-1) at pixel 502 leftwards.
// - Pattern one right half falls from 255-(n-1) at pixel 503 rightwards.
// - Pattern two is pattern one moving up one line per frame.
// - Pattern three columns 1..246 hold column plus 9.
// - Pattern three columns 247..502 hold column minus 247.
// - Pattern three right half line 1 is 235, reaching 0 at 236.
// - Pattern three right gradients restart at 255 on lines 237, 493, 749.
`timescale 1ns/1ns
module sbm_pixel_path
  import sbm_pkg::*;
#(
  parameter bit IS_COLOR = 1'b0,
  parameter int FRAME_OVH_CYC = SBM_FRAME_OVH_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic external_frame_trigger,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic sen_rd,
  output sbm_coord_t sen_addr,
  input wire logic [SBM_DW-1:0] sen_data,
  output logic pix_clk,
  output sbm_video_t video
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic trg_s1_r;
  logic trg_s2_r;
  logic trg_s3_r;
  logic trg_edge;
  logic trg_pend_r;
  logic start;
  sbm_ctrl_t ctrl_r;
  sbm_ctrl_t ctrl_eff;
  sbm_ctrl_t cfg_r;
  sbm_stat_t stat;
  sbm_state_t st_r;
  logic [9:0] col_r;
  logic [9:0] row_r;
  logic [9:0] cols_last;
  logic [9:0] rows_last;
  logic [9:0] s_col;
  logic [1:0] k_r;
  logic [1:0] k_last;
  logic vsub;
  logic rd_d_r;
  logic test_on;
  logic [7:0] tp_val;
  logic [SBM_ACC_W-1:0] src;
  logic [SBM_ACC_W-1:0] acc_r;
  logic [SBM_ACC_W-1:0] acc_sum;
  logic [SBM_DW-1:0] sat_val;
  logic [SBM_LT_W-1:0] line_tmr_r;
  logic [SBM_GAP_W-1:0] gap_tmr_r;
  logic [15:0] frm_cnt_r;
  logic [7:0] shift_r;
  logic fv_r;
  logic launch;
  logic pix_go;
  logic line_done;
  logic frame_done;
  sbm_coord_t pos;
  sbm_video_t video_r;
  logic [31:0] rdata_r;
  logic [10:0] px_cnt_r;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Control register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_r <= '0;
    else if (reg_wr && reg_addr == SBM_REG_CTRL)
      ctrl_r <= sbm_ctrl_t'(reg_wdata[$bits(sbm_ctrl_t)-1:0]);
  end

  // Colour variant masks binning
  always_comb
  begin
    ctrl_eff = ctrl_r;
    if (IS_COLOR)
    begin
      ctrl_eff.hbin = 1'b0;
      ctrl_eff.vbin = 1'b0;
    end
  end

  // Status word
  always_comb
  begin
    stat = '0;
    stat.frames = frm_cnt_r;
    stat.pend = trg_pend_r;
    stat.busy = (st_r != ST_IDLE);
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= '0;
    else if (reg_rd && reg_addr == SBM_REG_CTRL)
      rdata_r <= 32'(ctrl_eff);
    else if (reg_rd && reg_addr == SBM_REG_STAT)
      rdata_r <= stat;
    else
      rdata_r <= '0;
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Frame trigger
  // ----------------------------------------------------------------
  // Pin synchroniser and edge stage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trg_s1_r <= 1'b0;
      trg_s2_r <= 1'b0;
      trg_s3_r <= 1'b0;
    end
    else
    begin
      trg_s1_r <= external_frame_trigger;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
    end
  end

  assign trg_edge = trg_s2_r & ~trg_s3_r;

  // One pending frame per trigger cycle, set wins over clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      trg_pend_r <= 1'b0;
    else if (trg_edge && !ctrl_r.free_run)
      trg_pend_r <= 1'b1;
    else if (start)
      trg_pend_r <= 1'b0;
  end

  // Free-run restarts as soon as the previous frame cycle ends
  assign start = (st_r == ST_IDLE) && (ctrl_r.free_run || trg_pend_r);

  // Settings frozen for a whole frame
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_r <= '0;
    else if (start)
      cfg_r <= ctrl_eff;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign k_last = {cfg_r.hbin & cfg_r.vbin, cfg_r.hbin | cfg_r.vbin};
  assign cols_last = cfg_r.hbin ? SBM_HALF - 10'h001 : SBM_NCOL - 10'h001;
  assign rows_last = cfg_r.vbin ? SBM_HALF - 10'h001 : SBM_NCOL - 10'h001;
  assign pix_go = (st_r == ST_HOLD) && launch;
  assign line_done = (st_r == ST_LEND) && (line_tmr_r == '0) && launch;
  assign frame_done = line_done && (row_r == rows_last);

  // State and position
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= ST_IDLE;
      col_r <= '0;
      row_r <= '0;
      k_r <= '0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
          if (start)
          begin
            row_r <= '0;
            st_r <= ST_LINE;
          end
        ST_LINE:
        begin
          col_r <= '0;
          k_r <= '0;
          st_r <= ST_FETCH;
        end
        ST_FETCH:
          if (k_r == k_last)
            st_r <= ST_HOLD;
          else
            k_r <= k_r + 2'h1;
        ST_HOLD:
          if (pix_go)
          begin
            k_r <= '0;
            if (col_r == cols_last)
              st_r <= ST_LEND;
            else
            begin
              col_r <= col_r + 10'h001;
              st_r <= ST_FETCH;
            end
          end
        ST_LEND:
          if (frame_done)
            st_r <= ST_GAP;
          else if (line_done)
          begin
            row_r <= row_r + 10'h001;
            st_r <= ST_LINE;
          end
        ST_GAP:
          if (gap_tmr_r == '0)
            st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Line period and frame overhead; hbin alone keeps the normal line
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      line_tmr_r <= '0;
      gap_tmr_r <= '0;
    end
    else
    begin
      if (st_r == ST_LINE)
        line_tmr_r <= cfg_r.vbin ? SBM_LINE_VBIN_CYC : SBM_LINE_NORM_CYC;
      else if (line_tmr_r != '0)
        line_tmr_r <= line_tmr_r - SBM_LT_W'(1);
      if (frame_done)
        gap_tmr_r <= SBM_GAP_W'(FRAME_OVH_CYC - 1);
      else if (gap_tmr_r != '0)
        gap_tmr_r <= gap_tmr_r - SBM_GAP_W'(1);
    end
  end

  // Frame valid, frame count and pattern two shift
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fv_r <= 1'b0;
      frm_cnt_r <= '0;
      shift_r <= '0;
    end
    else if (start)
    begin
      fv_r <= 1'b1;
      frm_cnt_r <= frm_cnt_r + 16'h0001;
      shift_r <= shift_r + 8'h01;
    end
    else if (frame_done)
      fv_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sensor addressing and summing
  // ----------------------------------------------------------------
  assign s_col = cfg_r.hbin ? {col_r[8:0], k_r[0]} : col_r;
  assign vsub = cfg_r.hbin ? k_r[1] : k_r[0];
  assign pos.col = cfg_r.mirror ? SBM_NCOL - 10'h001 - s_col : s_col;
  assign pos.row = cfg_r.vbin ? {row_r[8:0], vsub} : row_r;
  assign test_on = (cfg_r.tp_sel != SBM_TP_OFF);
  assign sen_rd = (st_r == ST_FETCH) && !test_on;
  assign sen_addr = pos;

  sbm_pattern u_pattern (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sel(cfg_r.tp_sel),
    .shift(shift_r),
    .pos(pos),
    .val_r(tp_val)
  );

  // Pattern replaces sensor data, then goes through the same binning
  assign src = test_on ? SBM_ACC_W'(tp_val) : SBM_ACC_W'(sen_data);
  // Last read folded in on the fly, so a pixel may leave as its data arrives
  assign acc_sum = rd_d_r ? acc_r + src : acc_r;
  assign sat_val = (acc_sum > SBM_PIX_MAX) ? SBM_DW'(SBM_PIX_MAX) : acc_sum[SBM_DW-1:0];

  // Read data arrives one cycle after the read
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_d_r <= 1'b0;
    else
      rd_d_r <= (st_r == ST_FETCH);
  end

  // Charge sum of one output pixel
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      acc_r <= '0;
    else if (st_r == ST_LINE || pix_go)
      acc_r <= '0;
    else if (rd_d_r)
      acc_r <= acc_sum;
  end

  // ----------------------------------------------------------------
  // Link output
  // ----------------------------------------------------------------
  sbm_pixclk u_pixclk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .slow(cfg_r.hbin),
    .pix_clk(pix_clk),
    .launch(launch)
  );

  // One gray value per pixel, launched on the falling pixel clock edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      video_r <= '0;
    else if (launch)
    begin
      video_r.fval <= fv_r;
      video_r.lval <= pix_go;
      video_r.data <= pix_go ? sat_val : '0;
    end
  end

  assign video = video_r;

  // Pixels sent in the current line
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      px_cnt_r <= '0;
    else if (st_r == ST_LINE)
      px_cnt_r <= '0;
    else if (pix_go)
      px_cnt_r <= px_cnt_r + 11'h001;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_hpair;
    (st_r == ST_FETCH && k_r == 2'h0 && cfg_r.hbin && !cfg_r.vbin && !cfg_r.mirror)
      |=> (st_r == ST_FETCH && pos.col == $past(pos.col) + 10'h001 && pos.row == $past(pos.row));
  endproperty
  a_hpair: assert property (p_hpair) else $error("horizontal pair not adjacent");

  property p_vpair;
    (st_r == ST_FETCH && k_r == 2'h0 && !cfg_r.hbin && cfg_r.vbin)
      |=> (st_r == ST_FETCH && pos.row == $past(pos.row) + 10'h001 && pos.col == $past(pos.col));
  endproperty
  a_vpair: assert property (p_vpair) else $error("vertical pair not adjacent");

  property p_quad;
    (st_r == ST_FETCH && k_r == 2'h0 && cfg_r.hbin && cfg_r.vbin)
      |=> (st_r == ST_FETCH)[*3] ##1 (st_r == ST_HOLD);
  endproperty
  a_quad: assert property (p_quad) else $error("full binning did not read four pixels");

  property p_line_len;
    line_done |-> (px_cnt_r == 11'(cols_last) + 11'h001);
  endproperty
  a_line_len: assert property (p_line_len) else $error("wrong pixel count per line");

  property p_line_tmr;
    (st_r == ST_LINE) |=> (line_tmr_r == (cfg_r.vbin ? SBM_LINE_VBIN_CYC : SBM_LINE_NORM_CYC));
  endproperty
  a_line_tmr: assert property (p_line_tmr) else $error("wrong line period");

  property p_color;
    IS_COLOR |-> (!cfg_r.hbin && !cfg_r.vbin);
  endproperty
  a_color: assert property (p_color) else $error("binning active on colour variant");

  property p_mirror;
    (st_r == ST_FETCH && cfg_r.mirror && !cfg_r.hbin) |-> (pos.col == SBM_NCOL - 10'h001 - col_r);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror column wrong");

  property p_no_sensor;
    test_on |-> !sen_rd;
  endproperty
  a_no_sensor: assert property (p_no_sensor) else $error("sensor read during test pattern");

  property p_trig;
    (st_r == ST_IDLE && trg_pend_r && !ctrl_r.free_run && !trg_edge)
      |=> (st_r == ST_LINE && fv_r && !trg_pend_r);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not start a frame");

  property p_free;
    (st_r == ST_IDLE && ctrl_r.free_run) |=> (st_r == ST_LINE);
  endproperty
  a_free: assert property (p_free) else $error("free-run did not start a frame");

  property p_sat;
    (pix_go && acc_sum > SBM_PIX_MAX) |=> (video_r.lval && video_r.data == SBM_DW'(SBM_PIX_MAX));
  endproperty
  a_sat: assert property (p_sat) else $error("binned sum not saturated");

  c_frame_end: cover property (frame_done);
  c_full_bin: cover property (pix_go && cfg_r.hbin && cfg_r.vbin);
  c_tp3_mirror: cover property (pix_go && cfg_r.tp_sel == SBM_TP_THREE && cfg_r.mirror);

endmodule : sbm_pixel_path

// ==== rtl/sbm_pkg.sv ====
/*
  Shared constants and types of the binning, mirror and test pattern pixel path.
  Assumes a single 125 MHz core clock; times are given in ns and turned into cycles here.
*/
package sbm_pkg;

  // ----------------------------------------------------------------
  // Pixel geometry
  // ----------------------------------------------------------------
  localparam int SBM_DW = 10;
  localparam int SBM_ACC_W = SBM_DW + 2;
  localparam logic [9:0] SBM_NCOL = 10'h3ec;
  localparam logic [9:0] SBM_HALF = 10'h1f6;
  localparam logic [9:0] SBM_RIGHT0 = 10'h1f7;
  localparam logic [SBM_ACC_W-1:0] SBM_PIX_MAX = SBM_ACC_W'((1 << SBM_DW) - 1);

  // ----------------------------------------------------------------
  // Test pattern constants
  // ----------------------------------------------------------------
  localparam logic [7:0] SBM_GRAY_MAX = 8'hff;
  localparam logic [9:0] SBM_P3_BASE = 10'h00a;
  localparam logic [9:0] SBM_P3_SPLIT = 10'h0f6;
  localparam logic [9:0] SBM_P3_COL2 = 10'h0f7;
  localparam logic [9:0] SBM_P3_ROW1END = 10'h0ec;
  localparam logic [9:0] SBM_P3_ROW2 = 10'h0ed;
  localparam logic [1:0] SBM_TP_OFF = 2'h0;
  localparam logic [1:0] SBM_TP_ONE = 2'h1;
  localparam logic [1:0] SBM_TP_TWO = 2'h2;
  localparam logic [1:0] SBM_TP_THREE = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SBM_CLK_NS = 8;
  localparam int SBM_CLK_MHZ = 125;
  localparam int SBM_PIX_FAST_MHZ = 40;
  localparam int SBM_PIX_SLOW_MHZ = 20;
  localparam int SBM_LINE_NORM_NS = 20550;
  localparam int SBM_LINE_VBIN_NS = 27850;
  localparam int SBM_FRAME_OVH_NS = 204800;
  localparam int SBM_LT_W = 12;
  localparam logic [SBM_LT_W-1:0] SBM_LINE_NORM_CYC =
    SBM_LT_W'((SBM_LINE_NORM_NS + SBM_CLK_NS - 1) / SBM_CLK_NS);
  localparam logic [SBM_LT_W-1:0] SBM_LINE_VBIN_CYC =
    SBM_LT_W'((SBM_LINE_VBIN_NS + SBM_CLK_NS - 1) / SBM_CLK_NS);
  localparam int SBM_FRAME_OVH_CYC = (SBM_FRAME_OVH_NS + SBM_CLK_NS - 1) / SBM_CLK_NS;
  localparam int SBM_GAP_W = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SBM_REG_CTRL = 8'h00;
  localparam logic [7:0] SBM_REG_STAT = 8'h04;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic free_run;
    logic [1:0] tp_sel;
    logic mirror;
    logic vbin;
    logic hbin;
  } sbm_ctrl_t;

  typedef struct packed {
    logic [15:0] frames;
    logic [13:0] rsvd;
    logic pend;
    logic busy;
  } sbm_stat_t;

  typedef struct packed {
    logic [9:0] col;
    logic [9:0] row;
  } sbm_coord_t;

  typedef struct packed {
    logic fval;
    logic lval;
    logic [SBM_DW-1:0] data;
  } sbm_video_t;

  typedef enum logic [2:0] {ST_IDLE, ST_LINE, ST_FETCH, ST_HOLD, ST_LEND, ST_GAP} sbm_state_t;

endpackage : sbm_pkg

// ==== rtl/sbm_pixclk.sv ====
/*
  Pixel clock maker: a phase accumulator on the core clock toggles the link clock.
  Assumes the core clock rate in the package; the launch pulse marks the falling edge.
*/
`timescale 1ns/1ns
module sbm_pixclk
  import sbm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic slow,
  output logic pix_clk,
  output logic launch
);

  logic [7:0] acc_r;
  logic [7:0] step;
  logic [8:0] sum;
  logic wrap;
  logic pix_clk_r;

  // Two edges per pixel period
  assign step = slow ? 8'(SBM_PIX_SLOW_MHZ + SBM_PIX_SLOW_MHZ) : 8'(SBM_PIX_FAST_MHZ + SBM_PIX_FAST_MHZ);
  assign sum = {1'b0, acc_r} + {1'b0, step};
  assign wrap = sum >= 9'(SBM_CLK_MHZ);
  assign launch = wrap & pix_clk_r;
  assign pix_clk = pix_clk_r;

  // Phase accumulator
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      acc_r <= 8'h00;
    else if (wrap)
      acc_r <= 8'(sum - 9'(SBM_CLK_MHZ));
    else
      acc_r <= sum[7:0];
  end

  // Clock toggle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pix_clk_r <= 1'b0;
    else if (wrap)
      pix_clk_r <= ~pix_clk_r;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_slow_space;
    (launch && slow) |=> (!launch || !slow)[*5];
  endproperty
  a_slow_space: assert property (p_slow_space) else $error("slow pixel clock too fast");

  c_slow_launch: cover property (launch && slow);

endmodule : sbm_pixclk

// ==== rtl/sbm_pattern.sv ====
/*
  Test pattern generator: gray value of one sensor position, registered.
  Assumes 0-based sensor coordinates; the value is valid one cycle after the position.
*/
`timescale 1ns/1ns
module sbm_pattern
  import sbm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] sel,
  input wire logic [7:0] shift,
  input wire sbm_coord_t pos,
  output logic [7:0] val_r
);

  logic [9:0] c;
  logic [9:0] n;
  logic [7:0] val_nxt;

  // 1-based column and line, pattern two shifted per frame
  assign c = pos.col + 10'h001;
  assign n = pos.row + 10'h001 + ((sel == SBM_TP_TWO) ? {2'h0, shift} : 10'h000);

  // Pattern value
  always_comb
  begin
    val_nxt = 8'h00;
    case (sel)
      SBM_TP_ONE, SBM_TP_TWO:
        if (c <= SBM_HALF)
          val_nxt = SBM_GRAY_MAX - 8'(n - 10'h001) - 8'(SBM_HALF - c);
        else
          val_nxt = SBM_GRAY_MAX - 8'(n - 10'h001) - 8'(c - SBM_RIGHT0);
      SBM_TP_THREE:
        if (c <= SBM_P3_SPLIT)
          val_nxt = 8'(c + SBM_P3_BASE - 10'h001);
        else if (c <= SBM_HALF)
          val_nxt = 8'(c - SBM_P3_COL2);
        else if (n <= SBM_P3_ROW1END)
          val_nxt = 8'(SBM_P3_ROW1END - n);
        else
          val_nxt = SBM_GRAY_MAX - 8'(n - SBM_P3_ROW2);
      default: val_nxt = 8'h00;
    endcase
  end

  // Output register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      val_r <= 8'h00;
    else
      val_r <= val_nxt;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_tp1_ctr;
    (sel == SBM_TP_ONE && c == SBM_HALF) |=> (val_r == SBM_GRAY_MAX - 8'($past(n) - 10'h001));
  endproperty
  a_tp1_ctr: assert property (p_tp1_ctr) else $error("pattern one centre value wrong");

  property p_tp3_col;
    (sel == SBM_TP_THREE && c == SBM_P3_COL2) |=> (val_r == 8'h00);
  endproperty
  a_tp3_col: assert property (p_tp3_col) else $error("pattern three second ramp start wrong");

  property p_tp3_row;
    (sel == SBM_TP_THREE && c > SBM_HALF && n == SBM_P3_ROW1END) |=> (val_r == 8'h00);
  endproperty
  a_tp3_row: assert property (p_tp3_row) else $error("pattern three first gradient end wrong");

endmodule : sbm_pattern

// ==== tb/sbm_grabber.sv ====
/*
  Frame grabber model: samples the video word on pix_clk rise and pulses the trigger.
  Assumes video changes only where pix_clk falls; the trigger idles low.
*/
`timescale 1ns/1ns
module sbm_grabber
  import sbm_pkg::*;
(
  input wire logic pix_clk,
  input wire sbm_video_t video,
  input wire logic fire,
  output logic trig,
  output logic pix_ok,
  output logic [SBM_DW-1:0] pix
);
  // Capture on the receiving edge
  always @(posedge pix_clk)
  begin
    pix_ok <= video.fval & video.lval;
    pix <= video.data;
  end

  // One full trigger cycle per request
  initial trig = 1'b0;
  always @(posedge fire)
  begin
    trig = 1'b1;
    #402 trig = 1'b0;
  end
endmodule : sbm_grabber

// ==== tb/sbm_pixel_path_tb.sv ====
/*
  Testbench of the pixel path: register tasks, seeded sensor model, pixel scoreboard.
  Assumes the grabber model beside the design and a shortened frame gap.
*/
`timescale 1ns/1ns
module sbm_pixel_path_tb
  import sbm_pkg::*;
  ;
  logic core_clk, rst_b, reg_wr, reg_rd, sen_rd, pix_clk, trig, fire, pix_ok;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [SBM_DW-1:0] sen_data, pix;
  logic [SBM_DW-1:0] q[$];
  sbm_coord_t sen_addr;
  sbm_video_t video;
  int bad_count, samples_checked, cyc;

  sbm_pixel_path #(.FRAME_OVH_CYC(8)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .external_frame_trigger(trig), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sen_rd(sen_rd), .sen_addr(sen_addr),
    .sen_data(sen_data), .pix_clk(pix_clk), .video(video));
  sbm_grabber i_grab (.pix_clk(pix_clk), .video(video), .fire(fire), .trig(trig),
    .pix_ok(pix_ok), .pix(pix));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Seeded sensor value of a 0-based position
  function automatic logic [9:0] sval(input int c, input int r);
    logic [15:0] s;
    s = lfsr(lfsr(16'h41e7 ^ 16'(c) ^ 16'(r << 6)));
    return s[9:0];
  endfunction : sval

  // Source value at a 0-based sensor position
  function automatic int pv(input int tp, input int c0, input int r0);
    int c, n;
    c = c0 + 1;
    n = r0 + 1;
    // Pattern two: first frame after reset is already one line up
    if (tp == 2) n = r0 + 2;
    if (tp == 0) return sval(c0, r0);
    if (tp == 1 || tp == 2) return (c <= 502 ? c - 247 - (n - 1) : 758 - c - (n - 1)) & 255;
    if (c <= 246) return c + 9;
    if (c <= 502) return c - 247;
    return n <= 236 ? 236 - n : 255 - ((n - 237) % 256);
  endfunction : pv

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("TB: checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rd

  // Note expected pixels of the first lines of a frame
  task automatic expect_lines(input logic [5:0] ctl, input int lines);
    int w, s, col;
    w = ctl[0] ? 502 : 1004;
    for (int i = 0; i < lines; i++)
      for (int k = 0; k < w; k++)
      begin
        s = 0;
        for (int dr = 0; dr <= int'(ctl[1]); dr++)
          for (int dc = 0; dc <= int'(ctl[0]); dc++)
          begin
            col = ctl[0] ? 2 * k + dc : k;
            if (ctl[2]) col = 1003 - col;
            s += pv(int'(ctl[4:3]), col, ctl[1] ? 2 * i + dr : i);
          end
        q.push_back(SBM_DW'(s > 1023 ? 1023 : s));
      end
  endtask : expect_lines

  // Reset, configure, trigger if asked, drain the notes, time the pixel clock
  task automatic run(input logic [5:0] ctl, input int lines, input bit trg);
    int w;
    longint t;
    q.delete();
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    expect_lines(ctl, lines);
    rd(SBM_REG_CTRL, 32'h0);
    wr(SBM_REG_CTRL, {26'h0, ctl});
    rd(SBM_REG_CTRL, {26'h0, ctl});
    if (trg)
    begin
      repeat (300) @(posedge core_clk);
      rd(SBM_REG_STAT, 32'h0);
      fire <= 1'b1;
      repeat (2) @(posedge core_clk);
      fire <= 1'b0;
    end
    w = 0;
    while (q.size() > 0 && w < 4000 * lines + 4000)
    begin
      @(posedge core_clk);
      w++;
    end
    check(q.size(), 0);
    @(posedge pix_clk);
    t = $time;
    repeat (16) @(posedge pix_clk);
    w = int'(($time - t) / 8);
    check(32'(w >= (ctl[0] ? 99 : 49) && w <= (ctl[0] ? 101 : 51)), 1);
  endtask : run

  // Scoreboard: each captured pixel against the oldest note
  always @(negedge pix_clk)
    if (pix_ok === 1'b1 && q.size() > 0) check(pix, q.pop_front());

  // Sensor port, value of the addressed position one cycle later
  always @(posedge core_clk)
    sen_data <= sval(sen_addr.col, sen_addr.row);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang limit
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      bad_count++;
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    sen_data = 10'h000;
    fire = 1'b0;
    run(6'h38, 2, 1'b0);
    rd(SBM_REG_STAT, 32'h00010001);
    wr(SBM_REG_STAT, 32'hffffffff);
    rd(SBM_REG_STAT, 32'h00010001);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h0);
    run(6'h3c, 1, 1'b0);
    run(6'h39, 2, 1'b0);
    run(6'h08, 2, 1'b1);
    rd(SBM_REG_STAT, 32'h00010001);
    run(6'h30, 1, 1'b0);
    run(6'h21, 1, 1'b0);
    run(6'h22, 1, 1'b0);
    run(6'h23, 1, 1'b0);
    run(6'h24, 1, 1'b0);
    summarize();
  end
endmodule : sbm_pixel_path_tb
